// ===== core/kiu_pkg.sv
package kiu_pkg;
  // register map, byte offsets on the 8-bit register port
  localparam logic [7:0] KIU_PORT_DATA_OFS  = 8'h03; // port d data latch / pin levels
  localparam logic [7:0] KIU_PORT_DIR_OFS   = 8'h07; // port d direction bits
  localparam logic [7:0] KIU_STAT_CTRL_OFS  = 8'h1A; // key_status_control
  localparam logic [7:0] KIU_ENABLE_OFS     = 8'h1B; // key_enable_register
  // key_status_control field positions
  localparam int unsigned KIU_TRIG_BIT  = 0; // key_trigger_level_select
  localparam int unsigned KIU_MASK_BIT  = 1; // key_request_mask
  localparam int unsigned KIU_ACK_BIT   = 2; // key_acknowledge, write only
  localparam int unsigned KIU_FLAG_BIT  = 3; // key_pending_flag, read only
  // values after reset
  localparam logic [7:0] KIU_ENABLE_RST = 8'h00;
  localparam logic [7:0] KIU_DIR_RST    = 8'h00;
  localparam logic [7:0] KIU_DATA_RST   = 8'h00;
  localparam logic [7:0] KIU_RDATA_RST  = 8'h00;
  localparam logic       KIU_BIT_RST    = 1'b0;
endpackage : kiu_pkg

// ===== core/kiu_keyboard_interrupt_unit.sv
// Behaviour
// - eight key pins, each with own enable
// - enabled pin also turns on its pull-up
// - request latched when pins leave all-high
// - edge mode: no request while another low
// - level mode: request held while pin low
// - level mode clears after ack and release
// - vector fetch acknowledges the request
// - writing one to ack bit acknowledges
// - later falling edges latch new requests
// - unmasked request raises cpu interrupt
// - edge mode: ack clears request immediately
// - reset clears request and trigger select
// - pending flag readable regardless of mask
// - enabled pin forced to input
// - pin level read only with direction zero
// - mask bit blocks cpu interrupt; reset clears it
// - ack bit reads back as zero
//
// Decided for this implementation: the strobed register port and the register addresses.
module kiu_keyboard_interrupt_unit
  import kiu_pkg::*;
(
  input  wire logic       clk_i,          // 25 mhz system clock
  input  wire logic       sys_rst_i,      // synchronous, active high
  input  wire logic [7:0] addr_i,         // register address
  input  wire logic [7:0] wdata_i,        // register write data
  input  wire logic       wr_i,           // write strobe
  input  wire logic       rd_i,           // read strobe
  output logic      [7:0] rdata_o,        // read data, cycle after rd_i
  input  wire logic       vec_fetch_i,    // cpu fetches the keyboard vector
  output logic            key_irq_o,      // interrupt to cpu priority logic
  input  wire logic [7:0] port_d_pins_i,  // pin levels, asynchronous
  output logic      [7:0] port_d_pins_o,  // pin output data
  output logic      [7:0] port_d_pins_oe_o, // pin output enables
  output logic      [7:0] key_pullup_o    // pull-up enables
);

  // synchroniser and detection state
  logic [7:0] pin_meta_r;        // first stage, read only by second
  logic [7:0] pin_sync_r;        // second stage, safe to use
  logic       keys_low_prev_r;   // any enabled pin low last cycle
  // control registers
  logic [7:0] key_pin_enable_r;  // one enable per key pin
  logic       key_trigger_level_select_r; // edge+level when set
  logic       key_request_mask_r;         // masks cpu interrupt
  logic [7:0] port_dir_r;        // port d direction bits
  logic [7:0] port_data_r;       // port d data latch
  // request state
  logic       key_pending_flag_r; // latched keyboard request
  logic       ack_held_r;        // ack seen while pins still low
  logic       key_pending_flag_nxt;
  logic       ack_held_nxt;
  // decoded strobes and events
  logic       wr_stat;           // write to status/control
  logic       key_ack;           // acknowledge from any source
  logic       keys_low;          // any enabled pin low now
  logic       fall_trig;         // all-high to some-low transition
  logic       clr_ok;            // conditions allow clearing
  logic [7:0] rdata_nxt;

  // register selects, shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // port read mixes latch and pin by direction bit
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                           input logic [7:0] dat,
                                           input logic [7:0] pin);
    port_view = (dir & dat) | (~dir & pin);
  endfunction : port_view

  // pin synchroniser, two flops before any use
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta_r <= 8'hFF;
      pin_sync_r <= 8'hFF;
    end else begin
      pin_meta_r <= port_d_pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // strobes and level summary
  assign wr_stat   = wr_i && hit(addr_i, KIU_STAT_CTRL_OFS);
  // vector fetch or software write of a one
  assign key_ack   = vec_fetch_i
                   || (wr_stat && wdata_i[KIU_ACK_BIT]);
  // only enabled pins take part
  assign keys_low  = |(~pin_sync_r & key_pin_enable_r);
  // edge only when every enabled pin was high before
  assign fall_trig = keys_low && !keys_low_prev_r;
  // level mode needs pins back high as well
  assign clr_ok    = !key_trigger_level_select_r || !keys_low;

  // previous level for edge detection
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      keys_low_prev_r <= KIU_BIT_RST;
    end else begin
      keys_low_prev_r <= keys_low;
    end
  end

  // next request state, a new edge wins over a clear
  always_comb begin
    key_pending_flag_nxt = key_pending_flag_r;
    ack_held_nxt         = ack_held_r;
    if (fall_trig) begin
      // fresh edge, acks before it do not count
      key_pending_flag_nxt = 1'b1;
      ack_held_nxt         = 1'b0;
    end else if ((key_ack || ack_held_r) && clr_ok) begin
      // ack and release both seen, in any order
      key_pending_flag_nxt = 1'b0;
      ack_held_nxt         = 1'b0;
    end else if (key_ack && key_pending_flag_r) begin
      // level mode with a pin still low: remember ack
      ack_held_nxt         = 1'b1;
    end else if (!key_pending_flag_r) begin
      // nothing pending, nothing to remember
      ack_held_nxt         = 1'b0;
    end
  end

  // request latch, cleared by reset even with pins low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_pending_flag_r <= KIU_BIT_RST;
      ack_held_r         <= KIU_BIT_RST;
    end else begin
      key_pending_flag_r <= key_pending_flag_nxt;
      ack_held_r         <= ack_held_nxt;
    end
  end

  // status/control register; ack bit is not stored
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_trigger_level_select_r <= KIU_BIT_RST;
      key_request_mask_r         <= KIU_BIT_RST;
    end else if (wr_stat) begin
      key_trigger_level_select_r <= wdata_i[KIU_TRIG_BIT];
      key_request_mask_r         <= wdata_i[KIU_MASK_BIT];
    end
  end

  // key pin enable register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_pin_enable_r <= KIU_ENABLE_RST;
    end else if (wr_i && hit(addr_i, KIU_ENABLE_OFS)) begin
      key_pin_enable_r <= wdata_i;
    end
  end

  // port d direction and data latch; latch always writable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_dir_r  <= KIU_DIR_RST;
      port_data_r <= KIU_DATA_RST;
    end else begin
      if (wr_i && hit(addr_i, KIU_PORT_DIR_OFS)) begin
        port_dir_r <= wdata_i;
      end
      if (wr_i && hit(addr_i, KIU_PORT_DATA_OFS)) begin
        port_data_r <= wdata_i;
      end
    end
  end

  // pin drivers, enable overrides direction
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_d_pins_o    <= KIU_DATA_RST;
      port_d_pins_oe_o <= KIU_DIR_RST;
      key_pullup_o     <= KIU_ENABLE_RST;
    end else begin
      port_d_pins_o    <= port_data_r;
      port_d_pins_oe_o <= port_dir_r & ~key_pin_enable_r;
      key_pullup_o     <= key_pin_enable_r;
    end
  end

  // cpu interrupt, held off while masked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_irq_o <= KIU_BIT_RST;
    end else begin
      key_irq_o <= key_pending_flag_r && !key_request_mask_r;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(addr_i, KIU_STAT_CTRL_OFS)) begin
      // flag ignores mask, ack bit stays zero
      rdata_nxt[KIU_FLAG_BIT] = key_pending_flag_r;
      rdata_nxt[KIU_ACK_BIT]  = 1'b0;
      rdata_nxt[KIU_MASK_BIT] = key_request_mask_r;
      rdata_nxt[KIU_TRIG_BIT] = key_trigger_level_select_r;
    end else if (hit(addr_i, KIU_ENABLE_OFS)) begin
      rdata_nxt = key_pin_enable_r;
    end else if (hit(addr_i, KIU_PORT_DIR_OFS)) begin
      rdata_nxt = port_dir_r;
    end else if (hit(addr_i, KIU_PORT_DATA_OFS)) begin
      // pin level only where direction is input
      rdata_nxt = port_view(port_dir_r, port_data_r, pin_sync_r);
    end
  end

  // read data register, valid the cycle after rd_i
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= KIU_RDATA_RST;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= KIU_RDATA_RST;
    end
  end

  // checks, one domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // a qualifying edge always latches
  AST_EDGE_SETS: assert property (fall_trig |=> key_pending_flag_r)
    else $error("edge did not latch request");

  // no new edge while another enabled pin stays low
  AST_EDGE_BLOCKED: assert property (
    keys_low_prev_r && keys_low && !key_pending_flag_r
    |=> !key_pending_flag_r)
    else $error("request from edge while pin low");

  // level mode keeps request with a pin low
  AST_LEVEL_HOLDS: assert property (
    key_trigger_level_select_r && keys_low && key_pending_flag_r
    |=> key_pending_flag_r)
    else $error("level request dropped while pin low");

  // level mode: ack then release clears next cycle
  AST_LEVEL_RELEASE: assert property (
    key_trigger_level_select_r && ack_held_r && !keys_low && !fall_trig
    |=> !key_pending_flag_r)
    else $error("level request not cleared after release");

  // edge mode: any ack clears at once
  AST_EDGE_ACK: assert property (
    !key_trigger_level_select_r && (vec_fetch_i || wr_stat && wdata_i[KIU_ACK_BIT])
    && !fall_trig |=> !key_pending_flag_r)
    else $error("ack did not clear edge request");

  // unmasked request reaches cpu next cycle
  AST_IRQ_RAISE: assert property (
    key_pending_flag_r && !key_request_mask_r |=> key_irq_o)
    else $error("unmasked request not raised");

  // mask keeps interrupt low
  AST_MASK_BLOCKS: assert property (
    key_request_mask_r |=> !key_irq_o)
    else $error("masked request reached cpu");

  // reset clears request and trigger select
  AST_RESET_CLEARS: assert property (
    @(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> !key_pending_flag_r && !key_trigger_level_select_r && !key_irq_o)
    else $error("reset left request or mode set");

  // status read shows flag and never ack
  AST_STATUS_READ: assert property (
    rd_i && hit(addr_i, KIU_STAT_CTRL_OFS)
    |=> rdata_o[KIU_FLAG_BIT] == $past(key_pending_flag_r) && !rdata_o[KIU_ACK_BIT])
    else $error("status read wrong");

  // written enables appear as pull-ups two cycles on
  AST_PULLUP: assert property (
    wr_i && hit(addr_i, KIU_ENABLE_OFS) ##1 !(wr_i && hit(addr_i, KIU_ENABLE_OFS))
    |=> key_pullup_o == $past(wdata_i, 2))
    else $error("pull-up does not follow enable");

  // enabled pin never driven
  AST_DIR_OVERRIDE: assert property (
    ($past(key_pin_enable_r) & port_d_pins_oe_o) == 8'h00)
    else $error("enabled key pin driven");

  // port read picks pin only for input direction
  AST_PORT_READ: assert property (
    rd_i && hit(addr_i, KIU_PORT_DATA_OFS)
    |=> rdata_o == $past(port_view(port_dir_r, port_data_r, pin_sync_r)))
    else $error("port read mixes wrong source");

  // no request appears without a qualifying edge
  AST_NO_SPURIOUS: assert property (
    !key_pending_flag_r && !fall_trig
    |=> !key_pending_flag_r)
    else $error("request latched without edge");

  // disabled pins never latch a request
  AST_DISABLED_IGNORED: assert property (
    key_pin_enable_r == 8'h00 && !key_pending_flag_r
    |=> !key_pending_flag_r)
    else $error("request from disabled pins");

  // level mode: ack with a pin low is remembered
  AST_LEVEL_ACK_KEPT: assert property (
    key_trigger_level_select_r && key_ack && keys_low && key_pending_flag_r && !fall_trig
    |=> key_pending_flag_r && ack_held_r)
    else $error("level ack with pin low lost");

  // level mode: ack after release clears next cycle
  AST_LEVEL_ACK_LATE: assert property (
    key_trigger_level_select_r && key_ack && !keys_low
    |=> !key_pending_flag_r)
    else $error("late level ack did not clear");

  // vector fetch alone clears an edge request
  AST_VEC_FETCH: assert property (
    !key_trigger_level_select_r && vec_fetch_i && !fall_trig
    |=> !key_pending_flag_r)
    else $error("vector fetch did not acknowledge");

  // no request, no cpu interrupt
  AST_IRQ_DROP: assert property (
    !key_pending_flag_r |=> !key_irq_o)
    else $error("interrupt without request");

  // mask bit follows status writes
  AST_MASK_WRITE: assert property (
    wr_stat |=> key_request_mask_r == $past(wdata_i[KIU_MASK_BIT]))
    else $error("mask bit not written");

  // enable register reads back as written
  AST_ENABLE_READ: assert property (
    rd_i && hit(addr_i, KIU_ENABLE_OFS)
    |=> rdata_o == $past(key_pin_enable_r))
    else $error("enable register read wrong");

  // detection sees pins exactly two edges late
  AST_SYNC_STAGES: assert property (
    !$past(sys_rst_i) && !$past(sys_rst_i, 2)
    |-> pin_sync_r == $past(port_d_pins_i, 2))
    else $error("pin synchroniser depth wrong");

endmodule : kiu_keyboard_interrupt_unit

// ===== verif/kiu_key_switches.sv
// key switches and wiring on the far side of the key pins
module kiu_key_switches (
  input  wire logic       clk_i,   // system clock
  input  wire logic [7:0] press_i, // keys held down
  input  wire logic [7:0] pu_i,    // pull-up enables from device
  input  wire logic [7:0] oe_i,    // device drives pin
  input  wire logic [7:0] dout_i,  // device pin data
  output logic      [7:0] pin_o    // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flip_r = 8'h00; // undriven pins wander
  // floating pattern changes every cycle
  always @(posedge clk_i) begin
    flip_r <= ~flip_r;
  end
  // driver wins, then a pressed key, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) pin_o[i] = dout_i[i];
      else if (press_i[i]) pin_o[i] = 1'b0;
      else if (pu_i[i]) pin_o[i] = 1'b1;
      else pin_o[i] = flip_r[i];
    end
  end
endmodule : kiu_key_switches

// ===== verif/tb_top.sv
// register-level test of the keyboard interrupt unit
module tb_top
  import kiu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TRG = 8'h01 << KIU_TRIG_BIT; // level mode
  localparam logic [7:0] MSK = 8'h01 << KIU_MASK_BIT; // mask
  localparam logic [7:0] ACK = 8'h01 << KIU_ACK_BIT;  // acknowledge
  localparam logic [7:0] FLG = 8'h01 << KIU_FLAG_BIT; // pending
  localparam logic [7:0] STC = KIU_STAT_CTRL_OFS;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       vec_fetch_i = 1'b0;
  logic [7:0] press = 8'h00;
  logic [7:0] rdata_o, port_d_pins_o, port_d_pins_oe_o, key_pullup_o, pins;
  logic       key_irq_o;
  int         failures = 0;
  int         n_tests = 0;
  always #20 clk_i = ~clk_i;
  kiu_keyboard_interrupt_unit uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vec_fetch_i(vec_fetch_i),
    .key_irq_o(key_irq_o), .port_d_pins_i(pins), .port_d_pins_o(port_d_pins_o),
    .port_d_pins_oe_o(port_d_pins_oe_o), .key_pullup_o(key_pullup_o));
  kiu_key_switches keys (.clk_i(clk_i), .press_i(press), .pu_i(key_pullup_o),
    .oe_i(port_d_pins_oe_o), .dout_i(port_d_pins_o), .pin_o(pins));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk
  // set keys, then let sync and latch settle
  task automatic key_set(input logic [7:0] p);
    @(posedge clk_i);
    press <= p;
    repeat (6) @(posedge clk_i);
  endtask : key_set
  // vector fetch pulse
  task automatic vfetch;
    @(posedge clk_i);
    vec_fetch_i <= 1'b1;
    @(posedge clk_i);
    vec_fetch_i <= 1'b0;
  endtask : vfetch
  task automatic irq_chk(input logic e);
    chk({7'h00, key_irq_o}, {7'h00, e});
  endtask : irq_chk
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // verdict and stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(STC, 8'h00);
    rd_chk(KIU_ENABLE_OFS, KIU_ENABLE_RST);
    rd_chk(8'h55, 8'h00);
    irq_chk(1'b0);
    done("reset");
    wr(STC, MSK);
    wr(KIU_ENABLE_OFS, 8'h03);
    repeat (4) @(posedge clk_i);
    wr(STC, MSK | ACK);
    wr(STC, 8'h00);
    chk(key_pullup_o, 8'h03);
    rd_chk(STC, 8'h00);
    done("init");
    key_set(8'h01);
    rd_chk(STC, FLG);
    irq_chk(1'b1);
    wr(STC, ACK);
    rd_chk(STC, 8'h00);
    key_set(8'h03);
    rd_chk(STC, 8'h00);
    key_set(8'h00);
    key_set(8'h02);
    rd_chk(STC, FLG);
    vfetch();
    rd_chk(STC, 8'h00);
    irq_chk(1'b0);
    key_set(8'h00);
    done("edge");
    wr(STC, MSK);
    key_set(8'h01);
    rd_chk(STC, MSK | FLG);
    irq_chk(1'b0);
    wr(STC, MSK | ACK);
    key_set(8'h00);
    done("mask");
    wr(STC, TRG);
    key_set(8'h01);
    wr(STC, TRG | ACK);
    rd_chk(STC, TRG | FLG);
    irq_chk(1'b1);
    key_set(8'h00);
    rd_chk(STC, TRG);
    key_set(8'h01);
    key_set(8'h00);
    rd_chk(STC, TRG | FLG);
    vfetch();
    rd_chk(STC, TRG);
    done("level");
    wr(KIU_PORT_DIR_OFS, 8'hFF);
    wr(KIU_PORT_DATA_OFS, 8'hAA);
    chk(port_d_pins_oe_o, 8'hFC);
    rd_chk(KIU_PORT_DATA_OFS, 8'hAA);
    chk(port_d_pins_o, 8'hAA);
    wr(KIU_PORT_DIR_OFS, 8'hFC);
    repeat (4) @(posedge clk_i);
    rd_chk(KIU_PORT_DATA_OFS, 8'hAB);
    done("port");
    key_set(8'h01);
    rd_chk(STC, TRG | FLG);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(STC, 8'h00);
    irq_chk(1'b0);
    key_set(8'h00);
    done("rerun reset");
    // drive pins high first, let sync settle, then enable
    wr(KIU_PORT_DIR_OFS, 8'h0C);
    wr(KIU_PORT_DATA_OFS, 8'h0C);
    repeat (3) @(posedge clk_i);
    wr(KIU_ENABLE_OFS, 8'h0C);
    repeat (4) @(posedge clk_i);
    rd_chk(STC, 8'h00);
    chk(port_d_pins_oe_o, 8'h00);
    key_set(8'h04);
    rd_chk(STC, FLG);
    vfetch();
    rd_chk(STC, 8'h00);
    done("driven init");
    end_sim();
  end
endmodule : tb_top
